// [hw/isc_consts.vh]
// constants for the maskable interrupt service-mode controller
// assumes a byte-wide register port and 27 maskable sources
`ifndef ISC_CONSTS_VH
`define ISC_CONSTS_VH
// ----------------------------------------------------------------
// sizes
// ----------------------------------------------------------------
`define ISC_NSRC          27
`define ISC_AW            8
// ----------------------------------------------------------------
// register map (byte index), control registers at 0..26
// ----------------------------------------------------------------
`define ISC_A_CTRL_LAST   8'h1a
`define ISC_A_MASK_A_LO   8'h20
`define ISC_A_MASK_A_HI   8'h21
`define ISC_A_MASK_B_LO   8'h22
`define ISC_A_MASK_B_HI   8'h23
`define ISC_A_INSERV      8'h24
`define ISC_A_NEST        8'h25
`define ISC_A_NMISEL      8'h26
`define ISC_A_WDMODE      8'h27
`define ISC_A_PSW         8'h28
`define ISC_A_MACRO_DONE  8'h29
`define ISC_A_EVT_STAT    8'h2a
`define ISC_A_EVT_MASK    8'h2b
// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define ISC_B_REQ         7
`define ISC_B_MASK        6
`define ISC_B_MACRO       5
`define ISC_B_CTX         4
`define ISC_CTRL_RESET    8'h43
`define ISC_CTRL_WMASK    8'hf3
`define ISC_LVL_LOWEST    2'h3
// ----------------------------------------------------------------
// service mode codes
// ----------------------------------------------------------------
`define ISC_MODE_VECT     2'h0
`define ISC_MODE_MACRO    2'h1
`define ISC_MODE_CTX      2'h2
// ----------------------------------------------------------------
// small register fields
// ----------------------------------------------------------------
`define ISC_B_NEST_EN     0
`define ISC_B_SEL_PIN     0
`define ISC_B_SEL_WDT     1
`define ISC_B_WDM_PIN_HI  0
`define ISC_B_PSW_IE      0
`define ISC_EVT_ACK       0
`define ISC_EVT_MACRO     1
`define ISC_EVT_NMI       2
`endif

// [hw/isc_arbiter.v]
// priority arbiter over the maskable sources
// assumes level and eligibility vectors are stable within a cycle
`timescale 1ns/10ps
module isc_arbiter #(
  parameter NSRC = 27
) (
  input  wire [NSRC-1:0]   eligible_in,
  input  wire [2*NSRC-1:0] level_in,
  output reg               found_out,
  output reg  [4:0]        index_out,
  output reg  [1:0]        level_out
);
  integer i;
  // lowest level wins, ties go to lowest index (strict < keeps first)
  always @*
  begin
    found_out = 1'b0;
    index_out = 5'h00;
    level_out = 2'h3;
    for (i = 0; i < NSRC; i = i + 1)
    begin
      if (eligible_in[i] && (!found_out || level_in[2*i +: 2] < level_out))
      begin
        found_out = 1'b1;
        index_out = i[4:0];
        level_out = level_in[2*i +: 2];
      end
    end
  end
endmodule

// [hw/isc_ctrl_bank.v]
// bank of per-source control registers, registered read port
// assumes write and hardware events come from the controller top
`timescale 1ns/10ps
`include "isc_consts.vh"
module isc_ctrl_bank #(
  parameter NSRC = 27
) (
  input  wire              ref_clk_in,
  input  wire              rst_in,
  input  wire              wr_in,
  input  wire [4:0]        wr_idx_in,
  input  wire [7:0]        wr_data_in,
  input  wire              mask_wr_in,
  input  wire [NSRC-1:0]   mask_val_in,
  input  wire [NSRC-1:0]   req_set_in,
  input  wire [NSRC-1:0]   req_clr_in,
  input  wire [NSRC-1:0]   macro_clr_in,
  input  wire [4:0]        rd_idx_in,
  output reg  [7:0]        rd_data_out,
  output wire [NSRC-1:0]   req_out,
  output wire [NSRC-1:0]   mask_out,
  output wire [NSRC-1:0]   macro_out,
  output wire [NSRC-1:0]   ctx_out,
  output wire [2*NSRC-1:0] level_out
);
  reg [7:0] ctrl [0:NSRC-1];
  integer i;
  genvar g;
  always @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      for (i = 0; i < NSRC; i = i + 1)
        ctrl[i] <= `ISC_CTRL_RESET;
      rd_data_out <= 8'h00;
    end
    else
    begin
      rd_data_out <= ctrl[rd_idx_in];
      for (i = 0; i < NSRC; i = i + 1)
      begin
        if (wr_in && wr_idx_in == i[4:0])
          ctrl[i] <= wr_data_in & `ISC_CTRL_WMASK;
        if (mask_wr_in)
          ctrl[i][`ISC_B_MASK] <= mask_val_in[i];
        if (macro_clr_in[i])
          ctrl[i][`ISC_B_MACRO] <= 1'b0;
        // a new request beats the acknowledge clear
        if (req_clr_in[i])
          ctrl[i][`ISC_B_REQ] <= 1'b0;
        if (req_set_in[i])
          ctrl[i][`ISC_B_REQ] <= 1'b1;
      end
    end
  end
  generate
    for (g = 0; g < NSRC; g = g + 1)
    begin : fld
      assign req_out[g]         = ctrl[g][`ISC_B_REQ];
      assign mask_out[g]        = ctrl[g][`ISC_B_MASK];
      assign macro_out[g]       = ctrl[g][`ISC_B_MACRO];
      assign ctx_out[g]         = ctrl[g][`ISC_B_CTX];
      assign level_out[2*g +: 2] = ctrl[g][1:0];
    end
  endgenerate
endmodule

// [hw/isc_top.v]
// maskable interrupt service-mode controller, top level
// assumes a cpu core that takes ack_out, and byte register port with one-cycle read latency
// Function
// - vectored acknowledge: cpu saves pc and status word on stack, branches via vector
// - macro acknowledge: cpu paused while hardware moves data
// - macro transfer saves and restores no pc or status word
// - context acknowledge selects source bank and branches to its stored vector
// - context acknowledge saves pc and status word into bank with branch
// - exactly three service modes: vectored, macro, context switching
// - per-source control: request, mask, macro enable, context enable, two-bit level
// - fixed default priority 0 watchdog through 26 port falling edge
// - two mask words mirror mask flags, byte access only
// - in-service register records levels of acknowledged vectored and context requests
// - nesting control decides whether level 3 requests nest
// - selection register makes pin and watchdog maskable or non-maskable
// - watchdog mode register orders pin versus watchdog non-maskable
// - status word enable bit gates maskable acceptance except macro requests
// - control layout bits 7..4 flags, 3..2 zero, 1..0 level, reset 43h
// - level 00 highest, 11 lowest; ties by default order
// - request flag set by source, cleared by hardware on acknowledge
// - macro counter zero clears the source macro enable
`timescale 1ns/10ps
`include "isc_consts.vh"
module isc_top #(
  parameter NSRC = `ISC_NSRC
) (
  input  wire            ref_clk_in,
  input  wire            rst_in,
  input  wire [7:0]      addr_in,
  input  wire [7:0]      wdata_in,
  input  wire            wr_in,
  input  wire            rd_in,
  output reg  [7:0]      rdata_out,
  input  wire [NSRC-1:0] src_req_in,
  input  wire            external_int_pin_in,
  input  wire            watchdog_overflow_in,
  input  wire            ack_ready_in,
  input  wire            service_end_in,
  input  wire            macro_count_zero_in,
  output wire            ack_out,
  output reg  [4:0]      ack_index_out,
  output reg  [1:0]      ack_mode_out,
  output reg             save_to_stack_out,
  output reg             bank_switch_out,
  output reg             nmi_out,
  output reg             nmi_is_pin_out,
  output wire            irq_out
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  reg  [3:0] in_service_level_reg;
  reg  [3:0] lvl_stack [0:3];
  reg        lowest_level_nesting_ctrl;
  reg  [1:0] nonmaskable_select_reg;
  reg        watchdog_mode_reg;
  reg        global_maskable_enable;
  reg  [4:0] macro_index;
  reg        macro_busy;
  reg  [2:0] evt_stat;
  reg  [2:0] evt_mask;
  reg        nmi_busy;
  reg        nmi_pend_pin;
  reg        nmi_pend_wdt;
  reg        rd_ctrl;
  reg  [7:0] rd_hold;
  reg  [2:0] depth;
  wire [NSRC-1:0]   req;
  wire [NSRC-1:0]   mask;
  wire [NSRC-1:0]   macro;
  wire [NSRC-1:0]   ctx;
  wire [2*NSRC-1:0] level;
  wire [7:0]        ctrl_rdata;
  wire              found;
  wire [4:0]        win_idx;
  wire [1:0]        win_lvl;
  wire [31:0]       mask_word;
  reg  [31:0]       next_mask_word;
  reg  [NSRC-1:0]   req_set;
  reg  [NSRC-1:0]   req_clr;
  reg  [NSRC-1:0]   macro_clr;
  reg  [NSRC-1:0]   eligible;
  integer k;
  integer m;
  wire    nmi_take;
  wire    nmi_pin_first;

  // lowest level in service: level 3 needs nest enable to allow another level 3
  function level_allowed;
    input [1:0] lvl;
    input [3:0] busy;
    input       nest3;
    integer     j;
    begin
      level_allowed = 1'b1;
      for (j = 0; j < 4; j = j + 1)
        if (busy[j] && lvl >= j[1:0])
          level_allowed = 1'b0;
      if (lvl == `ISC_LVL_LOWEST && busy[`ISC_LVL_LOWEST] && nest3 && busy[2:0] == 3'h0)
        level_allowed = 1'b1;
    end
  endfunction

  // ----------------------------------------------------------------
  // source routing and eligibility
  // ----------------------------------------------------------------
  always @*
  begin
    req_set = src_req_in;
    // watchdog source 0 only as maskable when selected so
    req_set[0] = watchdog_overflow_in & ~nonmaskable_select_reg[`ISC_B_SEL_WDT];
    // pin source 1 likewise
    req_set[1] = external_int_pin_in & ~nonmaskable_select_reg[`ISC_B_SEL_PIN];
    for (k = 0; k < NSRC; k = k + 1)
    begin
      // macro requests bypass level and enable, but not mask
      if (macro[k])
        eligible[k] = req[k] & ~mask[k] & ~macro_busy;
      else
        eligible[k] = req[k] & ~mask[k] & global_maskable_enable
                      & level_allowed(level[2*k +: 2], in_service_level_reg, lowest_level_nesting_ctrl);
    end
  end

  isc_arbiter #(
    .NSRC (NSRC)
  ) u_arb (
    .eligible_in (eligible),
    .level_in    (level),
    .found_out   (found),
    .index_out   (win_idx),
    .level_out   (win_lvl)
  );

  // index order equals default priority 0..26
  assign ack_out = found & ack_ready_in & ~nmi_out;
  // pending non-maskable requests go one at a time, mode bit orders a tie
  assign nmi_take      = !nmi_busy && (nmi_pend_pin || nmi_pend_wdt);
  assign nmi_pin_first = nmi_pend_pin && (watchdog_mode_reg || !nmi_pend_wdt);

  always @*
  begin
    req_clr = {NSRC{1'b0}};
    macro_clr = {NSRC{1'b0}};
    if (ack_out)
      req_clr[win_idx] = 1'b1;
    if (macro_busy && macro_count_zero_in)
      macro_clr[macro_index] = 1'b1;
  end

  // ----------------------------------------------------------------
  // mask mirror words
  // ----------------------------------------------------------------
  assign mask_word = {{(32-NSRC){1'b0}}, mask};
  always @*
  begin
    next_mask_word = mask_word;
    case (addr_in)
      `ISC_A_MASK_A_LO: next_mask_word[7:0]   = wdata_in;
      `ISC_A_MASK_A_HI: next_mask_word[15:8]  = wdata_in;
      `ISC_A_MASK_B_LO: next_mask_word[23:16] = wdata_in;
      `ISC_A_MASK_B_HI: next_mask_word[31:24] = wdata_in;
      default:          next_mask_word = mask_word;
    endcase
  end

  isc_ctrl_bank #(
    .NSRC (NSRC)
  ) u_bank (
    .ref_clk_in   (ref_clk_in),
    .rst_in       (rst_in),
    .wr_in        (wr_in && addr_in <= `ISC_A_CTRL_LAST),
    .wr_idx_in    (addr_in[4:0]),
    .wr_data_in   (wdata_in),
    .mask_wr_in   (wr_in && addr_in >= `ISC_A_MASK_A_LO && addr_in <= `ISC_A_MASK_B_HI),
    .mask_val_in  (next_mask_word[NSRC-1:0]),
    .req_set_in   (req_set),
    .req_clr_in   (req_clr),
    .macro_clr_in (macro_clr),
    .rd_idx_in    (addr_in[4:0]),
    .rd_data_out  (ctrl_rdata),
    .req_out      (req),
    .mask_out     (mask),
    .macro_out    (macro),
    .ctx_out      (ctx),
    .level_out    (level)
  );

  // ----------------------------------------------------------------
  // acknowledge, service tracking, registers
  // ----------------------------------------------------------------
  always @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      in_service_level_reg      <= 4'h0;
      lowest_level_nesting_ctrl <= 1'b0;
      nonmaskable_select_reg    <= 2'h0;
      watchdog_mode_reg         <= 1'b0;
      global_maskable_enable    <= 1'b0;
      macro_index               <= 5'h00;
      macro_busy                <= 1'b0;
      evt_stat                  <= 3'h0;
      evt_mask                  <= 3'h0;
      nmi_busy                  <= 1'b0;
      nmi_pend_pin              <= 1'b0;
      nmi_pend_wdt              <= 1'b0;
      nmi_out                   <= 1'b0;
      nmi_is_pin_out            <= 1'b0;
      ack_index_out             <= 5'h00;
      ack_mode_out              <= `ISC_MODE_VECT;
      save_to_stack_out         <= 1'b0;
      bank_switch_out           <= 1'b0;
      rd_ctrl                   <= 1'b0;
      rd_hold                   <= 8'h00;
      depth                     <= 3'h0;
      for (m = 0; m < 4; m = m + 1)
        lvl_stack[m] <= 4'h0;
    end
    else
    begin
      save_to_stack_out <= 1'b0;
      bank_switch_out   <= 1'b0;
      nmi_out           <= 1'b0;
      // requests latch while another non-maskable service runs, so none is lost
      nmi_pend_pin <= (nmi_pend_pin & ~(nmi_take & nmi_pin_first)) |
                      (external_int_pin_in & nonmaskable_select_reg[`ISC_B_SEL_PIN]);
      nmi_pend_wdt <= (nmi_pend_wdt & ~(nmi_take & ~nmi_pin_first)) |
                      (watchdog_overflow_in & nonmaskable_select_reg[`ISC_B_SEL_WDT]);
      if (nmi_take)
      begin
        nmi_out        <= 1'b1;
        nmi_busy       <= 1'b1;
        nmi_is_pin_out <= nmi_pin_first;
      end
      else if (nmi_busy && service_end_in)
        nmi_busy <= 1'b0;
      if (ack_out)
      begin
        ack_index_out <= win_idx;
        if (macro[win_idx])
        begin
          ack_mode_out <= `ISC_MODE_MACRO;
          macro_busy   <= 1'b1;
          macro_index  <= win_idx;
        end
        else
        begin
          if (ctx[win_idx])
          begin
            ack_mode_out    <= `ISC_MODE_CTX;
            bank_switch_out <= 1'b1;
          end
          else
          begin
            ack_mode_out      <= `ISC_MODE_VECT;
            save_to_stack_out <= 1'b1;
          end
          in_service_level_reg <= in_service_level_reg | (4'h1 << win_lvl);
          lvl_stack[depth[1:0]] <= in_service_level_reg;
          depth <= depth + 3'h1;
        end
      end
      else if (service_end_in && !nmi_busy && depth != 3'h0)
      begin
        in_service_level_reg <= lvl_stack[depth[1:0] - 2'h1];
        depth <= depth - 3'h1;
      end
      if (macro_busy && (macro_count_zero_in || service_end_in))
        macro_busy <= 1'b0;
      // events: set wins over write-one clear
      evt_stat <= (evt_stat & ~((wr_in && addr_in == `ISC_A_EVT_STAT) ? wdata_in[2:0] : 3'h0))
                  | {nmi_out, macro_busy & macro_count_zero_in, ack_out};
      if (wr_in)
      begin
        case (addr_in)
          `ISC_A_NEST:     lowest_level_nesting_ctrl <= wdata_in[`ISC_B_NEST_EN];
          `ISC_A_NMISEL:   nonmaskable_select_reg    <= wdata_in[1:0];
          `ISC_A_WDMODE:   watchdog_mode_reg         <= wdata_in[`ISC_B_WDM_PIN_HI];
          `ISC_A_PSW:      global_maskable_enable    <= wdata_in[`ISC_B_PSW_IE];
          `ISC_A_EVT_MASK: evt_mask                  <= wdata_in[2:0];
          default:         evt_mask                  <= evt_mask;
        endcase
      end
      rd_ctrl <= rd_in && addr_in <= `ISC_A_CTRL_LAST;
      case (addr_in)
        `ISC_A_MASK_A_LO: rd_hold <= mask_word[7:0];
        `ISC_A_MASK_A_HI: rd_hold <= mask_word[15:8];
        `ISC_A_MASK_B_LO: rd_hold <= mask_word[23:16];
        `ISC_A_MASK_B_HI: rd_hold <= mask_word[31:24];
        `ISC_A_INSERV:    rd_hold <= {4'h0, in_service_level_reg};
        `ISC_A_NEST:      rd_hold <= {7'h00, lowest_level_nesting_ctrl};
        `ISC_A_NMISEL:    rd_hold <= {6'h00, nonmaskable_select_reg};
        `ISC_A_WDMODE:    rd_hold <= {7'h00, watchdog_mode_reg};
        `ISC_A_PSW:       rd_hold <= {7'h00, global_maskable_enable};
        `ISC_A_MACRO_DONE: rd_hold <= {2'h0, macro_busy, macro_index};
        `ISC_A_EVT_STAT:  rd_hold <= {5'h00, evt_stat};
        `ISC_A_EVT_MASK:  rd_hold <= {5'h00, evt_mask};
        default:          rd_hold <= 8'h00;
      endcase
    end
  end

  always @*
  begin
    rdata_out = rd_ctrl ? ctrl_rdata : rd_hold;
  end

  assign irq_out = |(evt_stat & evt_mask);
endmodule

// [verification/isc_chk_sva.sv]
// assertions on the controller top ports
// assumes it is bound onto isc_top; one clock domain
`timescale 1ns/10ps
`include "isc_consts.vh"
module isc_chk (
  input wire       ref_clk_in,
  input wire       rst_in,
  input wire [7:0] addr_in,
  input wire       rd_in,
  input wire [7:0] rdata_out,
  input wire       ack_ready_in,
  input wire       ack_out,
  input wire [1:0] ack_mode_out,
  input wire       save_to_stack_out,
  input wire       bank_switch_out,
  input wire       nmi_out
);
  default clocking dcb @(posedge ref_clk_in);
  endclocking
  default disable iff (rst_in);
  // ----------------------------------------------------------------
  // acknowledge outcome
  // ----------------------------------------------------------------
  a_ack_needs_ready: assert property (ack_out |-> ack_ready_in)
    else $error("ack while cpu not ready");
  a_vect_saves_pc: assert property ($past(ack_out) && ack_mode_out == `ISC_MODE_VECT
    |-> save_to_stack_out && !bank_switch_out) else $error("vectored ack without stack save");
  a_ctx_bank_sel: assert property ($past(ack_out) && ack_mode_out == `ISC_MODE_CTX
    |-> bank_switch_out && !save_to_stack_out) else $error("context ack without bank switch");
  a_macro_no_save: assert property ($past(ack_out) && ack_mode_out == `ISC_MODE_MACRO
    |-> !save_to_stack_out && !bank_switch_out) else $error("macro ack saved state");
  a_save_from_ack: assert property (save_to_stack_out || bank_switch_out |-> $past(ack_out))
    else $error("save or bank pulse without ack");
  a_mode_three: assert property ($past(ack_out) |-> ack_mode_out != 2'h3)
    else $error("illegal service mode");
  a_nmi_single: assert property (nmi_out |=> !nmi_out)
    else $error("nmi taken twice in a row");
  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  a_ctrl_gap_zero: assert property (rd_in && addr_in <= `ISC_A_CTRL_LAST |=> rdata_out[3:2] == 2'b00)
    else $error("control bits 3..2 not zero");
  c_vect: cover property ($past(ack_out) && ack_mode_out == `ISC_MODE_VECT);
  c_ctx: cover property ($past(ack_out) && ack_mode_out == `ISC_MODE_CTX);
  c_macro: cover property ($past(ack_out) && ack_mode_out == `ISC_MODE_MACRO);
  c_nmi: cover property (nmi_out);
endmodule

// [verification/isc_cpu_model.sv]
// cpu core stand-in: takes acks, ends services, ends macro runs
// assumes ack mode is registered one cycle after the ack pulse
`timescale 1ns/10ps
`include "isc_consts.vh"
module isc_cpu_model (
  input  wire       ref_clk_in,
  input  wire       rst_in,
  input  wire       hold_in,
  input  wire       slow_in,
  input  wire       ack_in,
  input  wire [1:0] mode_in,
  input  wire       nmi_in,
  output reg        ready_out,
  output reg        end_out,
  output reg        count_zero_out
);
  reg       ack_d;
  reg [3:0] open_n;
  reg [1:0] gap;
  wire      fin = open_n != 4'h0 && !hold_in && gap == 2'h3;
  // macro units open no service: nothing to restore
  wire      opn = (ack_d && mode_in != `ISC_MODE_MACRO) || nmi_in;
  always @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      ack_d <= 1'b0;
      ready_out <= 1'b0;
      end_out <= 1'b0;
      count_zero_out <= 1'b0;
      open_n <= 4'h0;
      gap <= 2'h0;
    end
    else
    begin
      ack_d <= ack_in;
      ready_out <= slow_in ? ~ready_out : 1'b1;
      // one-unit transfers: every macro run ends at once
      count_zero_out <= ack_d && mode_in == `ISC_MODE_MACRO;
      end_out <= fin;
      open_n <= open_n + {3'b000, opn} - {3'b000, fin};
      gap <= (open_n == 4'h0 || hold_in) ? 2'h0 : gap + 2'h1;
    end
  end
endmodule

// [verification/isc_top_tb.sv]
// self-checking bench for the interrupt service-mode controller
// assumes hw/ on the include path and the cpu stand-in model
`timescale 1ns/10ps
`include "isc_consts.vh"
module isc_top_tb;
  reg         clk;
  reg         rst;
  reg         wr_s;
  reg         rd_s;
  reg  [7:0]  addr;
  reg  [7:0]  wdata;
  reg  [26:0] req;
  reg         pin;
  reg         wdt;
  reg         hold;
  reg         slow;
  reg  [7:0]  d;
  wire [7:0]  rdata;
  wire [4:0]  idx;
  wire [1:0]  mode;
  wire        ack, save, bank, nmi, nmi_pin, irq, ready, send, czero;
  integer     miscompares, n_checks, cyc, i, n, a, b, la, lb, ca, cb, w, k;
  isc_top isc_top_inst (.ref_clk_in(clk), .rst_in(rst), .addr_in(addr), .wdata_in(wdata),
    .wr_in(wr_s), .rd_in(rd_s), .rdata_out(rdata), .src_req_in(req), .external_int_pin_in(pin),
    .watchdog_overflow_in(wdt), .ack_ready_in(ready), .service_end_in(send),
    .macro_count_zero_in(czero), .ack_out(ack), .ack_index_out(idx), .ack_mode_out(mode),
    .save_to_stack_out(save), .bank_switch_out(bank), .nmi_out(nmi), .nmi_is_pin_out(nmi_pin),
    .irq_out(irq));
  isc_cpu_model isc_cpu_model_inst (.ref_clk_in(clk), .rst_in(rst), .hold_in(hold), .slow_in(slow),
    .ack_in(ack), .mode_in(mode), .nmi_in(nmi), .ready_out(ready), .end_out(send),
    .count_zero_out(czero));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task chk(input [8*12-1:0] nm, input [31:0] seen, input [31:0] exp);
    begin
      n_checks = n_checks + 1;
      if (seen !== exp)
      begin
        miscompares = miscompares + 1;
        $display("CHECK FAILED %0s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task give_verdict;
    begin
      if (miscompares == 0 && n_checks > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  task wr(input [7:0] a_, input [7:0] d_);
    begin
      @(posedge clk);
      addr <= a_;
      wdata <= d_;
      wr_s <= 1'b1;
      @(posedge clk);
      wr_s <= 1'b0;
      #1;
    end
  endtask
  task rdc(input [7:0] a_, input [7:0] m, input [7:0] e);
    begin
      @(posedge clk);
      addr <= a_;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      #1;
      d = rdata;
      if (m != 8'h00)
        chk("register", d & m, e);
    end
  endtask
  task pulse(input [26:0] v);
    begin
      @(posedge clk);
      req <= v;
      @(posedge clk);
      req <= 27'h0;
    end
  endtask
  // bounded wait for ack (s=0) or nmi (s=1), up to 60 cycles
  task wsig(input s);
    begin
      k = 0;
      #1;
      while ((s ? nmi : ack) !== 1'b1 && k < 60)
      begin
        @(posedge clk);
        #1;
        k = k + 1;
      end
      chk("handshake", k < 60, 1);
    end
  endtask
  task wack(input [4:0] ei, input [1:0] em);
    begin
      wsig(1'b0);
      @(posedge clk);
      #1;
      chk("ack index", idx, ei);
      chk("ack mode", mode, em);
      chk("stack save", save, em == `ISC_MODE_VECT);
      chk("bank switch", bank, em == `ISC_MODE_CTX);
    end
  endtask
  task wnmi(input p);
    begin
      wsig(1'b1);
      chk("nmi source", nmi_pin, p);
      @(posedge clk);
    end
  endtask
  task idle;
    begin
      d = 8'hff;
      for (n = 0; n < 30 && d !== 8'h00; n = n + 1)
        rdc(`ISC_A_INSERV, 8'h00, 8'h00);
      chk("in service", d, 8'h00);
    end
  endtask
  function integer winner(input integer a_, input integer la_, input integer b_, input integer lb_);
    winner = (lb_ < la_ || (lb_ == la_ && b_ < a_)) ? b_ : a_;
  endfunction
  // ----------------------------------------------------------------
  // clock, timeout and sequence
  // ----------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
      miscompares = miscompares + 1;
      give_verdict;
    end
  end
  initial
  begin
    {rst, wr_s, rd_s, addr, wdata, req, pin, wdt, hold, slow} = {1'b1, 49'h0};
    {miscompares, n_checks, cyc} = 0;
    d = $urandom(32'h630a);
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 27; i = i + 1)
      rdc(i[7:0], 8'hff, `ISC_CTRL_RESET);
    rdc(`ISC_A_MASK_A_LO, 8'hff, 8'hff);
    rdc(`ISC_A_MASK_B_HI, 8'h07, 8'h07);
    for (i = 0; i < 27; i = i + 1)
    begin
      w = $urandom & 32'h5f;
      wr(i[7:0], w[7:0]);
      rdc(i[7:0], 8'hff, w[7:0] & `ISC_CTRL_WMASK);
      rdc(8'h20 + i / 8, 8'h01 << (i % 8), w[6] << (i % 8));
    end
    wr(`ISC_A_MASK_A_HI, 8'hff);
    rdc(8'h0a, 8'h40, 8'h40);
    wr(8'h40, 8'hff);
    rdc(8'h40, 8'hff, 8'h00);
    wr(`ISC_A_PSW, 8'h01);
    for (i = 0; i < 12; i = i + 1)
    begin
      a = 2 + $urandom % 25;
      b = 2 + (a - 1 + $urandom % 24) % 25;
      la = $urandom % 4;
      lb = $urandom % 4;
      ca = $urandom % 2;
      cb = $urandom % 2;
      slow <= i[0];
      wr(a[7:0], {3'b000, ca[0], 2'b00, la[1:0]});
      wr(b[7:0], {3'b000, cb[0], 2'b00, lb[1:0]});
      pulse((27'h1 << a) | (27'h1 << b));
      w = winner(a, la, b, lb);
      wack(w[4:0], ((w == a) ? ca[0] : cb[0]) ? `ISC_MODE_CTX : `ISC_MODE_VECT);
      w = a + b - w;
      wack(w[4:0], ((w == a) ? ca[0] : cb[0]) ? `ISC_MODE_CTX : `ISC_MODE_VECT);
      rdc(a[7:0], 8'h80, 8'h00);
      rdc(b[7:0], 8'h80, 8'h00);
      idle;
    end
    slow <= 1'b0;
    wr(`ISC_A_PSW, 8'h00);
    wr(8'h09, 8'h00);
    pulse(27'h1 << 9);
    rdc(8'h09, 8'h80, 8'h80);
    wr(`ISC_A_PSW, 8'h01);
    wack(5'd9, `ISC_MODE_VECT);
    idle;
    hold <= 1'b1;
    wr(8'h05, 8'h03);
    pulse(27'h1 << 5);
    wack(5'd5, `ISC_MODE_VECT);
    rdc(`ISC_A_INSERV, 8'hff, 8'h08);
    wr(8'h06, 8'h03);
    pulse(27'h1 << 6);
    rdc(8'h06, 8'h80, 8'h80);
    wr(`ISC_A_NEST, 8'h01);
    wack(5'd6, `ISC_MODE_VECT);
    hold <= 1'b0;
    idle;
    wr(8'h07, 8'h20);
    pulse(27'h1 << 7);
    wack(5'd7, `ISC_MODE_MACRO);
    wr(`ISC_A_EVT_MASK, 8'h07);
    rdc(8'h07, 8'h20, 8'h00);
    chk("irq", irq, 1'b1);
    pulse(27'h1 << 7);
    wack(5'd7, `ISC_MODE_VECT);
    wr(`ISC_A_NMISEL, 8'h03);
    for (i = 0; i < 2; i = i + 1)
    begin
      wr(`ISC_A_WDMODE, i[7:0]);
      @(posedge clk);
      {pin, wdt} <= 2'b11;
      @(posedge clk);
      {pin, wdt} <= 2'b00;
      wnmi(i[0]);
      wnmi(!i[0]);
    end
    wr(`ISC_A_NMISEL, 8'h00);
    wr(8'h01, 8'h00);
    @(posedge clk);
    pin <= 1'b1;
    @(posedge clk);
    pin <= 1'b0;
    wack(5'd1, `ISC_MODE_VECT);
    idle;
    wr(`ISC_A_EVT_MASK, 8'h00);
    chk("irq masked", irq, 1'b0);
    wr(`ISC_A_EVT_MASK, 8'h07);
    chk("irq raised", irq, 1'b1);
    wr(`ISC_A_EVT_STAT, 8'h07);
    chk("irq cleared", irq, 1'b0);
    give_verdict;
  end
endmodule
bind isc_top isc_chk isc_chk_inst (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .addr_in(addr_in),
  .rd_in(rd_in), .rdata_out(rdata_out), .ack_ready_in(ack_ready_in), .ack_out(ack_out),
  .ack_mode_out(ack_mode_out), .save_to_stack_out(save_to_stack_out),
  .bank_switch_out(bank_switch_out), .nmi_out(nmi_out));
